// ### i2ct_cfg.svh
// Purpose: Constants for the two-wire target port and its host controller.
// Assumes: System clock of 40 MHz on both ends.
// Notes:   Definitions only.
`ifndef I2CT_CFG_SVH
`define I2CT_CFG_SVH
`define I2CT_ADDR_HI        6'b10_0100
`define I2CT_BYTE_BITS      4'h8
`define I2CT_FILT_LEN       2'h3
`define I2CT_CLK_NS         25
`define I2CT_HALF_NS        5000
`define I2CT_HALF_CYC       (((`I2CT_HALF_NS) + (`I2CT_CLK_NS) - 1) / (`I2CT_CLK_NS))
`define I2CT_STRETCH_CYC    8'h10
`endif

// ### i2ct_host.sv
// Purpose: Two-wire host controller: one command of write bytes or read bytes.
// Assumes: Single host on the bus; SCL made here by a divider of mclk_i.
// Notes:   Repeated start on request lets a subaddress write precede a read.
`timescale 1ns/100ps
`default_nettype none
`include "i2ct_cfg.svh"
module i2ct_host (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// Bus
	i2ct_if.host            bus,
	// Command
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic [6:0] cmd_addr_i,
	input  wire logic       cmd_read_i,
	input  wire logic [7:0] cmd_len_i,
	input  wire logic       cmd_restart_i,
	// Write data in
	input  wire logic [7:0] tx_data_i,
	output logic            tx_take_o,
	// Read data out and result
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	output logic            done_o,
	output logic            nack_o
);
	localparam int HALF = `I2CT_HALF_CYC;
	logic [1:0]  scl_s_r, sda_s_r;
	logic [15:0] tmr_r;
	i2ct_pkg::i2ct_hstate_type st_r;
	logic        scl_oe_r, sda_oe_r, rd_r, rs_r, ph_r, addr_ph_r;
	logic [7:0]  sh_r, len_r;
	logic [3:0]  bit_r;
	wire scl_in = scl_s_r[1];
	wire sda_in = sda_s_r[1];
	wire tick   = tmr_r == 16'(HALF - 1);
	wire mid    = tmr_r == 16'(HALF / 2);
	wire idle   = scl_in & sda_in;
	wire stalled = ~scl_oe_r & ~scl_in;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_s_r <= 2'b11;
			sda_s_r <= 2'b11;
		end else begin
			scl_s_r <= {scl_s_r[0], bus.scl};
			sda_s_r <= {sda_s_r[0], bus.sda};
		end
	end

	// -----------------------------------------------------------------
	// Bit engine; ph_r=0 SCL low half, 1 SCL high half
	// -----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= i2ct_pkg::HST_IDLE; tmr_r <= 16'h0000; scl_oe_r <= 1'b0; sda_oe_r <= 1'b0;
			rd_r <= 1'b0; rs_r <= 1'b0; ph_r <= 1'b0; addr_ph_r <= 1'b0; sh_r <= 8'h00;
			len_r <= 8'h00; bit_r <= 4'h0; rx_data_o <= 8'h00; rx_valid_o <= 1'b0;
			tx_take_o <= 1'b0; done_o <= 1'b0; nack_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			tx_take_o  <= 1'b0;
			done_o     <= 1'b0;
			// Timer frozen while a target stretches the clock
			tmr_r <= (tick || st_r == i2ct_pkg::HST_IDLE) ? 16'h0000 : (stalled ? tmr_r : tmr_r + 16'h0001);
			case (st_r)
				i2ct_pkg::HST_IDLE: if (cmd_valid_i && idle) begin
					sda_oe_r <= 1'b1;
					rd_r <= cmd_read_i; rs_r <= cmd_restart_i; len_r <= cmd_len_i;
					sh_r <= {cmd_addr_i, cmd_read_i};
					bit_r <= 4'h0; addr_ph_r <= 1'b1; nack_o <= 1'b0;
					st_r <= i2ct_pkg::HST_START;
				end
				i2ct_pkg::HST_START: if (tick) begin
					scl_oe_r <= 1'b1; ph_r <= 1'b0; st_r <= i2ct_pkg::HST_BIT;
				end
				i2ct_pkg::HST_BIT: begin
					// Data moves in mid low half, clear of both SCL edges, for setup and hold
					if (!ph_r && mid) begin
						if (bit_r == `I2CT_BYTE_BITS) begin
							// Ack slot: release for target ack, or on reads drive ack, releasing for nack after the last byte
							sda_oe_r <= (rd_r && !addr_ph_r) ? (len_r != 8'h01) : 1'b0;
						end else begin
							sda_oe_r <= (rd_r && !addr_ph_r) ? 1'b0 : ~sh_r[7];
						end
					end
					if (tick && !ph_r) begin
						if (bit_r == `I2CT_BYTE_BITS) st_r <= i2ct_pkg::HST_ACK;
						scl_oe_r <= 1'b0;
						ph_r     <= 1'b1;
					end else if (tick) begin
						if (rd_r && !addr_ph_r) sh_r <= {sh_r[6:0], sda_in};
						else sh_r <= {sh_r[6:0], 1'b0};
						bit_r <= bit_r + 4'h1; scl_oe_r <= 1'b1; ph_r <= 1'b0;
					end
				end
				i2ct_pkg::HST_ACK: if (tick) begin
					if (!ph_r) begin
						scl_oe_r <= 1'b0; ph_r <= 1'b1;
					end else begin
						scl_oe_r <= 1'b1; ph_r <= 1'b0; bit_r <= 4'h0;
						if (rd_r && !addr_ph_r) begin
							rx_data_o <= sh_r; rx_valid_o <= 1'b1; len_r <= len_r - 8'h01;
							st_r <= (len_r == 8'h01) ? i2ct_pkg::HST_DONE : i2ct_pkg::HST_BIT;
						end else if (sda_in) begin
							nack_o <= 1'b1; st_r <= i2ct_pkg::HST_DONE;
						end else if (len_r == 8'h00 || (rd_r && len_r == 8'h00)) begin
							st_r <= i2ct_pkg::HST_DONE;
						end else begin
							addr_ph_r <= 1'b0;
							if (!rd_r) begin
								sh_r <= tx_data_i; tx_take_o <= 1'b1; len_r <= len_r - 8'h01;
							end
							st_r <= i2ct_pkg::HST_BIT;
						end
					end
				end
				i2ct_pkg::HST_DONE: if (tick) begin
					sda_oe_r <= ~rs_r | nack_o; // Low for stop, high for repeated start
					st_r <= (rs_r && !nack_o) ? i2ct_pkg::HST_RSTRT : i2ct_pkg::HST_STOP;
					ph_r <= 1'b0;
				end
				i2ct_pkg::HST_STOP: if (tick) begin
					if (!ph_r) begin
						scl_oe_r <= 1'b0; ph_r <= 1'b1;
					end else begin
						sda_oe_r <= 1'b0; done_o <= 1'b1; st_r <= i2ct_pkg::HST_IDLE;
					end
				end
				i2ct_pkg::HST_RSTRT: if (tick) begin
					// Bus left held with SCL high, SDA high for the next start
					scl_oe_r <= 1'b0; done_o <= 1'b1; st_r <= i2ct_pkg::HST_IDLE;
				end
				default: st_r <= i2ct_pkg::HST_IDLE;
			endcase
		end
	end

	assign bus.scl_oe_host = scl_oe_r;
	assign bus.sda_oe_host = sda_oe_r;
	assign cmd_ready_o     = (st_r == i2ct_pkg::HST_IDLE) & idle;
endmodule : i2ct_host
`default_nettype wire

// ### i2ct_if.sv
// Purpose: Two-wire bus carrier joining host and target ends.
// Assumes: Both lines open drain with pull-ups.
// Notes:   Wire level is low whenever any enable is high.
`timescale 1ns/100ps
`default_nettype none
interface i2ct_if;
	logic scl_oe_host;
	logic sda_oe_host;
	logic scl_oe_tgt;
	logic sda_oe_tgt;
	logic scl;
	logic sda;
	assign scl = ~(scl_oe_host | scl_oe_tgt);
	assign sda = ~(sda_oe_host | sda_oe_tgt);
	modport host (output scl_oe_host, output sda_oe_host, input scl, input sda);
	modport target (output scl_oe_tgt, output sda_oe_tgt, input scl, input sda);
endinterface : i2ct_if
`default_nettype wire

// ### i2ct_pkg.sv
// Purpose: Shared types for the two-wire target port and host controller.
// Assumes: Included constants header is compiled first.
// Notes:   Types only.
package i2ct_pkg;
	typedef enum logic [5:0] {
		TGT_IDLE = 6'b00_0001,
		TGT_RECV = 6'b00_0010,
		TGT_RACK = 6'b00_0100,
		TGT_SEND = 6'b00_1000,
		TGT_SACK = 6'b01_0000,
		TGT_SKIP = 6'b10_0000
	} i2ct_tstate_type;
	typedef enum logic [6:0] {
		HST_IDLE  = 7'b000_0001,
		HST_START = 7'b000_0010,
		HST_BIT   = 7'b000_0100,
		HST_ACK   = 7'b000_1000,
		HST_STOP  = 7'b001_0000,
		HST_RSTRT = 7'b010_0000,
		HST_DONE  = 7'b100_0000
	} i2ct_hstate_type;
endpackage : i2ct_pkg

// ### i2ct_sva.sv
// Purpose: Bus checker for the two-wire host and target pair.
// Assumes: Lines idle high; host half period far above the target filter delay.
// Notes:   Bit counter restarts at every start condition.
`timescale 1ns/100ps
`default_nettype none
module i2ct_sva (
	// Clock, reset and strap
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic address_select_pin_i,
	// Bus
	input  wire logic scl_oe_host,
	input  wire logic sda_oe_host,
	input  wire logic scl_oe_tgt,
	input  wire logic sda_oe_tgt,
	input  wire logic scl,
	input  wire logic sda
);
	// ----------------------------------------
	// Bit tracking
	// ----------------------------------------
	logic       scl_r;
	logic       sda_r;
	logic       first_r;
	logic       read_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	wire        start_w = scl & scl_r & sda_r & ~sda;
	wire        stop_w  = scl & scl_r & ~sda_r & sda;
	wire        rise_w  = scl & ~scl_r;
	wire        slot_w  = rise_w & (cnt_r == 4'h8);
	wire        own_w   = (sh_r[7:1] == {6'h24, address_select_pin_i});
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{scl_r, sda_r, first_r, read_r} <= 4'hc;
			cnt_r <= 4'h0;
			sh_r  <= 8'h00;
		end else begin
			{scl_r, sda_r} <= {scl, sda};
			if (start_w) begin
				cnt_r   <= 4'h0;
				first_r <= 1'h1;
			end else if (rise_w) begin
				cnt_r   <= slot_w ? 4'h0 : cnt_r + 4'h1;
				sh_r    <= {sh_r[6:0], sda};
				first_r <= first_r & ~slot_w;
				read_r  <= (slot_w & first_r) ? sh_r[0] : read_r;
			end
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Data may only move while the clock line is low
	a_sda_low_phase: assert property ($changed(sda_oe_tgt) |-> !scl)
		else $error("target moved SDA while SCL high");
	a_stretch_on_low: assert property ($rose(scl_oe_tgt) |-> !scl && !$past(scl))
		else $error("target grabbed SCL while high");
	a_start_quiet: assert property (start_w |-> (!sda_oe_tgt && !scl_oe_tgt) [*8])
		else $error("target drove the bus after start");
	a_stop_idle: assert property (stop_w |-> (!sda_oe_tgt && !scl_oe_tgt && !sda_oe_host && !scl_oe_host) [*8])
		else $error("bus not idle after stop");
	a_own_addr_ack: assert property (slot_w && first_r && own_w |-> sda_oe_tgt)
		else $error("own address not acknowledged");
	a_foreign_quiet: assert property (slot_w && first_r && !own_w |-> !sda_oe_tgt [*8])
		else $error("foreign address acknowledged");
	// Stop comes four host half periods later, each stretched by two sync clocks where SCL is let go
	a_nack_release: assert property (slot_w && !first_r && read_r && sda |->
		!sda_oe_tgt throughout (##[1:820] stop_w))
		else $error("target kept sending after host nack");
	a_host_waits: assert property ($fell(scl_oe_tgt) && !scl_oe_host |=> scl [*8])
		else $error("host cut high phase after stretch");
endmodule : i2ct_sva
`default_nettype wire

// ### i2ct_target.sv
// Purpose: Two-wire target port: address match, byte receive and send, stretching.
// Assumes: Bus lines asynchronous to mclk_i; SCL low phase well above 10 clocks.
// Notes:   User side gets written bytes and supplies read bytes on request.
`timescale 1ns/100ps
`default_nettype none
`include "i2ct_cfg.svh"
module i2ct_target (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// Bus
	i2ct_if.target          bus,
	// Strap
	input  wire logic       address_select_pin_i,
	// Write data to user
	output logic [7:0]      wr_data_o,
	output logic            wr_valid_o,
	output logic            wr_first_o,
	input  wire logic       wr_ready_i,
	// Read data from user
	output logic            rd_req_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i,
	// Status
	output logic            busy_o,
	output logic            stop_o
);
	logic [1:0] scl_sync_r, sda_sync_r;
	logic [1:0] scl_cnt_r, sda_cnt_r;
	logic       scl_f_r, sda_f_r, scl_d_r, sda_d_r;
	logic       addr_lsb_r;
	logic [1:0] strap_sync_r;
	i2ct_pkg::i2ct_tstate_type state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic       first_r, first_nxt;
	logic       sda_oe_r, sda_oe_nxt;
	logic       hold_r, hold_nxt;
	logic       need_r, need_nxt;
	logic       ack_r, ack_nxt;
	logic [7:0] wr_data_nxt;
	logic       wr_valid_nxt, wr_first_nxt, rd_req_nxt;

	// -----------------------------------------------------------------
	// Input conditioning
	// -----------------------------------------------------------------
	// Two flops, then a level must hold for FILT_LEN samples to pass
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_sync_r <= 2'b11;
			sda_sync_r <= 2'b11;
			scl_cnt_r  <= 2'h0;
			sda_cnt_r  <= 2'h0;
			scl_f_r    <= 1'b1;
			sda_f_r    <= 1'b1;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			scl_cnt_r  <= (scl_sync_r[1] == scl_f_r) ? 2'h0 : scl_cnt_r + 2'h1;
			sda_cnt_r  <= (sda_sync_r[1] == sda_f_r) ? 2'h0 : sda_cnt_r + 2'h1;
			if (scl_cnt_r == `I2CT_FILT_LEN - 2'h1) scl_f_r <= scl_sync_r[1];
			if (sda_cnt_r == `I2CT_FILT_LEN - 2'h1) sda_f_r <= sda_sync_r[1];
			scl_d_r    <= scl_f_r;
			sda_d_r    <= sda_f_r;
		end
	end

	wire scl_rise  = scl_f_r & ~scl_d_r;
	wire scl_fall  = ~scl_f_r & scl_d_r;
	wire start_det = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
	wire stop_det  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;
	wire [6:0] own_addr = {`I2CT_ADDR_HI, addr_lsb_r};
	wire addr_hit  = shift_r[7:1] == own_addr;

	// Strap is a pin: two flops first, then caught only while idle so a match never moves mid-frame
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_sync_r <= 2'b11;
			addr_lsb_r   <= 1'b1;
		end else begin
			strap_sync_r <= {strap_sync_r[0], address_select_pin_i};
			if (state_r == i2ct_pkg::TGT_IDLE) addr_lsb_r <= strap_sync_r[1];
		end
	end

	// -----------------------------------------------------------------
	// Protocol engine
	// -----------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		shift_nxt    = shift_r;
		bit_nxt      = bit_r;
		first_nxt    = first_r;
		sda_oe_nxt   = sda_oe_r;
		hold_nxt     = hold_r;
		need_nxt     = need_r;
		ack_nxt      = ack_r;
		wr_data_nxt  = wr_data_o;
		wr_valid_nxt = 1'b0;
		wr_first_nxt = wr_first_o;
		rd_req_nxt   = 1'b0;
		if (stop_det) begin
			state_nxt  = i2ct_pkg::TGT_IDLE;
			sda_oe_nxt = 1'b0;
			hold_nxt   = 1'b0;
			need_nxt   = 1'b0;
		end else if (start_det) begin
			state_nxt  = i2ct_pkg::TGT_RECV;
			first_nxt  = 1'b1;
			bit_nxt    = 4'h0;
			sda_oe_nxt = 1'b0;
			hold_nxt   = 1'b0;
			need_nxt   = 1'b0;
		end else begin
			case (state_r)
				i2ct_pkg::TGT_IDLE: begin
					sda_oe_nxt = 1'b0;
					hold_nxt   = 1'b0;
				end
				i2ct_pkg::TGT_RECV: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_f_r};
						bit_nxt   = bit_r + 4'h1;
					end
					if (scl_fall && bit_r == `I2CT_BYTE_BITS) begin
						bit_nxt = 4'h0;
						if (first_r) begin
							if (addr_hit) begin
								sda_oe_nxt = 1'b1;
								ack_nxt    = shift_r[0];
								state_nxt  = i2ct_pkg::TGT_RACK;
							end else begin
								state_nxt = i2ct_pkg::TGT_SKIP;
							end
						end else if (wr_ready_i) begin
							sda_oe_nxt   = 1'b1;
							ack_nxt      = 1'b0;
							wr_data_nxt  = shift_r;
							wr_valid_nxt = 1'b1;
							state_nxt    = i2ct_pkg::TGT_RACK;
						end else begin
							state_nxt = i2ct_pkg::TGT_SKIP;
						end
					end
				end
				i2ct_pkg::TGT_RACK: begin
					// Ack held low across SCL high; decided at the falling edge
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						if (first_r && ack_r) begin
							first_nxt  = 1'b0;
							state_nxt  = i2ct_pkg::TGT_SEND;
							need_nxt   = 1'b1;
							hold_nxt   = 1'b1;
							rd_req_nxt = 1'b1;
						end else begin
							wr_first_nxt = first_r;
							first_nxt    = 1'b0;
							state_nxt    = i2ct_pkg::TGT_RECV;
						end
					end
				end
				i2ct_pkg::TGT_SEND: begin
					if (need_r) begin
						hold_nxt = 1'b1;
						if (rd_valid_i) begin
							shift_nxt  = rd_data_i;
							sda_oe_nxt = ~rd_data_i[7];
							bit_nxt    = 4'h1;
							need_nxt   = 1'b0;
						end
					end else if (hold_r) begin
						// First bit settles a clock before SCL is let go, never on the rising edge
						hold_nxt = 1'b0;
					end else if (scl_fall) begin
						if (bit_r == `I2CT_BYTE_BITS) begin
							sda_oe_nxt = 1'b0;
							state_nxt  = i2ct_pkg::TGT_SACK;
						end else begin
							sda_oe_nxt = ~shift_r[3'h7 - bit_r[2:0]];
							bit_nxt    = bit_r + 4'h1;
						end
					end
				end
				i2ct_pkg::TGT_SACK: begin
					if (scl_rise) ack_nxt = sda_f_r;
					if (scl_fall) begin
						if (ack_r) begin
							state_nxt = i2ct_pkg::TGT_SKIP;
						end else begin
							state_nxt  = i2ct_pkg::TGT_SEND;
							need_nxt   = 1'b1;
							hold_nxt   = 1'b1;
							rd_req_nxt = 1'b1;
						end
					end
				end
				i2ct_pkg::TGT_SKIP: begin
					sda_oe_nxt = 1'b0;
					hold_nxt   = 1'b0;
				end
				default: begin
					state_nxt  = i2ct_pkg::TGT_IDLE;
					sda_oe_nxt = 1'b0;
					hold_nxt   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r    <= i2ct_pkg::TGT_IDLE;
			shift_r    <= 8'h00;
			bit_r      <= 4'h0;
			first_r    <= 1'b0;
			sda_oe_r   <= 1'b0;
			hold_r     <= 1'b0;
			need_r     <= 1'b0;
			ack_r      <= 1'b0;
			wr_data_o  <= 8'h00;
			wr_valid_o <= 1'b0;
			wr_first_o <= 1'b0;
			rd_req_o   <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			shift_r    <= shift_nxt;
			bit_r      <= bit_nxt;
			first_r    <= first_nxt;
			sda_oe_r   <= sda_oe_nxt;
			hold_r     <= hold_nxt;
			need_r     <= need_nxt;
			ack_r      <= ack_nxt;
			wr_data_o  <= wr_data_nxt;
			wr_valid_o <= wr_valid_nxt;
			wr_first_o <= wr_first_nxt;
			rd_req_o   <= rd_req_nxt;
		end
	end

	assign bus.sda_oe_tgt = sda_oe_r;
	assign bus.scl_oe_tgt = hold_r;
	assign busy_o         = state_r != i2ct_pkg::TGT_IDLE;
	assign stop_o         = stop_det;
endmodule : i2ct_target
`default_nettype wire

// ### test_i2c_target_port.sv
// Purpose: Self-checking bench for the host and target ends of the two-wire port.
// Assumes: Host half period of 200 clocks; strap low selects the lower address.
// Notes:   Read bytes come late on purpose so the target must stretch SCL.
`timescale 1ns/100ps
`default_nettype none
module test_i2c_target_port;
	logic       mclk_i      = 1'h0;
	logic       rst_n_i     = 1'h0;
	logic       strap       = 1'h0;
	logic       cmd_valid   = 1'h0;
	logic       cmd_read    = 1'h0;
	logic       cmd_restart = 1'h0;
	logic [6:0] cmd_addr    = 7'h00;
	logic [7:0] cmd_len     = 8'h00;
	logic       wr_ready    = 1'h1;
	logic [7:0] rd_data     = 8'h00;
	logic       rd_valid    = 1'h0;
	logic       stretched   = 1'h0;
	logic [7:0] tx_arr [4]  = '{default: 8'h00};
	logic [7:0] rd_arr [4]  = '{default: 8'h00};
	logic [7:0] got_q [$];
	logic       first_q [$];
	int         ti, ri, stops, errors, checks, cycles;
	wire        cmd_ready, tx_take, rx_valid, done, nack, wr_valid, wr_first, rd_req, busy, stop;
	wire  [7:0] rx_data, wr_data;
	wire  [7:0] tx_data = tx_arr[ti];
	// ----------------------------------------
	// Both ends and the checker
	// ----------------------------------------
	i2ct_if bus_if ();
	i2ct_host i2ct_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.host), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_addr_i(cmd_addr), .cmd_read_i(cmd_read), .cmd_len_i(cmd_len),
		.cmd_restart_i(cmd_restart), .tx_data_i(tx_data), .tx_take_o(tx_take), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .done_o(done), .nack_o(nack));
	i2ct_target i2ct_target_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.target),
		.address_select_pin_i(strap), .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_first_o(wr_first),
		.wr_ready_i(wr_ready), .rd_req_o(rd_req), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .busy_o(busy),
		.stop_o(stop));
	i2ct_sva i2ct_sva_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_select_pin_i(strap),
		.scl_oe_host(bus_if.scl_oe_host), .sda_oe_host(bus_if.sda_oe_host), .scl_oe_tgt(bus_if.scl_oe_tgt),
		.sda_oe_tgt(bus_if.sda_oe_tgt), .scl(bus_if.scl), .sda(bus_if.sda));
	always #12.5 mclk_i = ~mclk_i;
	// ----------------------------------------
	// Monitors and user-side responder
	// ----------------------------------------
	// Index moves on the edge after the take pulse, so the host never sees a half-changed byte
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (tx_take === 1'h1) ti <= ti + 1;
		if (cycles > 90000) begin
			errors++;
			conclude();
		end
	end
	always @(negedge mclk_i) begin
		if (wr_valid === 1'h1) begin
			got_q.push_back(wr_data);
			first_q.push_back(wr_first);
		end
		if (rx_valid === 1'h1) got_q.push_back(rx_data);
		if (stop === 1'h1) stops++;
		if (bus_if.scl_oe_tgt === 1'h1) stretched = 1'h1;
	end
	// Answers each read request after 300 clocks, beyond the host half period
	initial forever begin
		@(posedge mclk_i);
		if (rd_req === 1'h1) begin
			repeat (300) @(negedge mclk_i);
			rd_data  = rd_arr[ri];
			rd_valid = 1'h1;
			@(negedge mclk_i);
			rd_valid = 1'h0;
			ri++;
		end
	end
	// ----------------------------------------
	// Tasks and scenarios
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic run(input logic [6:0] addr, input logic rd, input logic [7:0] len, input logic rs);
		ti = 0;
		ri = 0;
		stops = 0;
		got_q = {};
		first_q = {};
		stretched = 1'h0;
		@(negedge mclk_i);
		{cmd_addr, cmd_read, cmd_len, cmd_restart} = {addr, rd, len, rs};
		cmd_valid = 1'h1;
		while (cmd_ready !== 1'h1) @(negedge mclk_i);
		@(negedge mclk_i);
		cmd_valid = 1'h0;
		while (done !== 1'h1) @(negedge mclk_i);
		repeat (20) @(negedge mclk_i);
		if (!rs) check("busy", 8'h00, {7'h00, busy});
	endtask : run
	task automatic t_write();
		tx_arr = '{8'h5a, 8'hc3, 8'h81, 8'h00};
		run(7'h48, 1'h0, 8'h03, 1'h0);
		check("nack", 8'h00, {7'h00, nack});
		check("count", 8'h03, 8'(got_q.size()));
		foreach (got_q[i]) check("wr byte", tx_arr[i], got_q[i]);
		check("first", 8'h02, {6'h00, first_q[0], first_q[1]});
		check("stops", 8'h01, 8'(stops));
		$display("t_write done");
	endtask : t_write
	task automatic t_strap();
		strap = 1'h1;
		tx_arr[0] = 8'h3c;
		run(7'h49, 1'h0, 8'h01, 1'h0);
		check("nack 49", 8'h00, {7'h00, nack});
		check("count 49", 8'h01, 8'(got_q.size()));
		run(7'h48, 1'h0, 8'h01, 1'h0);
		check("nack 48", 8'h01, {7'h00, nack});
		check("count 48", 8'h00, 8'(got_q.size()));
		strap = 1'h0;
		run(7'h48, 1'h0, 8'h00, 1'h0);
		check("addr only nack", 8'h00, {7'h00, nack});
		check("addr only count", 8'h00, 8'(got_q.size()));
		$display("t_strap done");
	endtask : t_strap
	task automatic t_refuse();
		wr_ready = 1'h0;
		run(7'h48, 1'h0, 8'h02, 1'h0);
		check("refused", 8'h01, {7'h00, nack});
		wr_ready = 1'h1;
		$display("t_refuse done");
	endtask : t_refuse
	task automatic t_read();
		tx_arr[0] = 8'h02;
		rd_arr = '{8'ha5, 8'h3c, 8'hf0, 8'h00};
		run(7'h48, 1'h0, 8'h01, 1'h1);
		check("subaddr", 8'h02, got_q[0]);
		run(7'h48, 1'h1, 8'h03, 1'h0);
		check("rd count", 8'h03, 8'(got_q.size()));
		foreach (got_q[i]) check("rd byte", rd_arr[i], got_q[i]);
		check("stretch", 8'h01, {7'h00, stretched});
		check("rd reqs", 8'h03, 8'(ri));
		check("rd nack", 8'h00, {7'h00, nack});
		$display("t_read done");
	endtask : t_read
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(negedge mclk_i);
		rst_n_i = 1'h1;
		repeat (4) @(negedge mclk_i);
		t_write();
		t_strap();
		t_refuse();
		t_read();
		conclude();
	end
endmodule : test_i2c_target_port
`default_nettype wire
